// ---- pkg/fsep_pkg.sv ----
// Package for the flash segment erase/program sequencer: geometry, commands, tags, timing.
package fsep_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int MAIN_SEG_BYTES = 512;
   localparam int INFO_SEG_BYTES = 64;
   localparam int INFO_SEG_COUNT = 4;
   localparam int MAIN_SEG_COUNT = 8; // Variant dependent, plain default
   localparam int MAIN_BYTES = MAIN_SEG_BYTES * MAIN_SEG_COUNT;
   localparam int INFO_BYTES = INFO_SEG_BYTES * INFO_SEG_COUNT;
   localparam int MAIN_AW = $clog2(MAIN_BYTES);
   localparam int INFO_AW = $clog2(INFO_BYTES);
   localparam int MAIN_SEG_SHIFT = $clog2(MAIN_SEG_BYTES);
   localparam int INFO_SEG_SHIFT = $clog2(INFO_SEG_BYTES);
   localparam int SEG_A_INDEX = 0;
   // ------------------------------------------------------------
   // Address windows of the two regions
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] INFO_BASE = 16'h1000;
   localparam logic [ADDR_W-1:0] MAIN_BASE = 16'h1100;
   // ------------------------------------------------------------
   // Erased value and calibration record tags
   // ------------------------------------------------------------
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] OSCILLATOR_CALIBRATION_TAG = 8'h01;
   localparam logic [7:0] CONVERTER_CALIBRATION_TAG = 8'h10;
   localparam logic [7:0] EMPTY_AREA_TAG = 8'hfe;
   localparam logic [7:0] CAL_RECORD_LEN = 8'h08;
   // ------------------------------------------------------------
   // Timing: two clock cycles per byte touched
   // ------------------------------------------------------------
   localparam int STEP_CYCLES = 2;
   localparam logic [1:0] STEP_LAST = 2'(STEP_CYCLES - 1);
   // ------------------------------------------------------------
   // Commands and requesters
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FSEP_CMD_READ,
      FSEP_CMD_PROG_BYTE,
      FSEP_CMD_PROG_WORD,
      FSEP_CMD_ERASE_SEG,
      FSEP_CMD_ERASE_MAIN,
      FSEP_CMD_ERASE_ALL,
      FSEP_CMD_READ_MARGIN0,
      FSEP_CMD_READ_MARGIN1
   } fsep_cmd_type;
   typedef enum logic [1:0] {
      FSEP_SRC_CPU,
      FSEP_SRC_LOADER,
      FSEP_SRC_TEST
   } fsep_src_type;
endpackage

// ---- rtl/fsep_array.sv ----
// Flash cell array model: byte storage with clear-to-ones, program-to-zero and margin reads.
module fsep_array (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Cell access
   input wire logic [fsep_pkg::ADDR_W-1:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic er_en,
   input wire logic [1:0] margin,
   output logic [7:0] rd_data
);
   logic [7:0] cell_ff [fsep_pkg::MAIN_BYTES + fsep_pkg::INFO_BYTES];
   logic [7:0] weak_ff [fsep_pkg::MAIN_BYTES + fsep_pkg::INFO_BYTES];
   localparam int DEPTH = fsep_pkg::MAIN_BYTES + fsep_pkg::INFO_BYTES;
   localparam int IDX_W = $clog2(DEPTH);
   logic [IDX_W-1:0] idx;
   logic [7:0] raw;

   // ------------------------------------------------------------
   // Address map: info bytes first, main array after them
   // ------------------------------------------------------------
   always_comb begin
      if (addr < fsep_pkg::MAIN_BASE) begin
         idx = IDX_W'(addr - fsep_pkg::INFO_BASE);
      end else begin
         idx = IDX_W'(addr - fsep_pkg::MAIN_BASE) + IDX_W'(fsep_pkg::INFO_BYTES);
      end
   end

   // Cells only clear bits on program; erase sets them back to ones.
   // Freshly programmed zeros are marked weak until the next erase so
   // margin reads have something to disagree on.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            cell_ff[i] <= fsep_pkg::ERASED_BYTE;
            weak_ff[i] <= 8'h00;
         end
      end else if (er_en) begin
         cell_ff[idx] <= fsep_pkg::ERASED_BYTE;
         weak_ff[idx] <= 8'h00;
      end else if (wr_en) begin
         cell_ff[idx] <= cell_ff[idx] & wr_data;
         weak_ff[idx] <= weak_ff[idx] | (cell_ff[idx] & ~wr_data);
      end
   end

   // Margin select 1 reads weak zeros as ones; 0 reads the cells as stored
   assign raw = cell_ff[idx];
   always_comb begin
      unique case (margin)
         2'h1: rd_data = raw | weak_ff[idx];
         default: rd_data = raw;
      endcase
   end
endmodule

// ---- rtl/fsep_ctrl.sv ----
// Flash segment erase/program sequencer: request arbitration, lock, erase walk, margin reads.
// Contract
// - The core may program a single byte or a single 16-bit word into flash.
// - Program and erase requests are taken from the core, the boot loader and the test port.
// - Main flash erases in segments of 512 bytes, with a variant-set segment count.
// - Information flash is four separately addressed 64-byte segments A to D.
// - Main flash erases one segment alone or all main segments in one operation.
// - Info segments erase one at a time or together with all main segments at once.
// - Segment A is locked after every reset and software may unlock it.
// - Marginal read modes let software check the retention margin of cells.
// - Segment A holds tag-length-value calibration records with tags 0x01, 0x10 and 0xfe.
module fsep_ctrl (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Requests, one per source
   input wire logic [2:0] req_valid,
   input wire fsep_pkg::fsep_cmd_type [2:0] req_cmd,
   input wire logic [2:0][fsep_pkg::ADDR_W-1:0] req_addr,
   input wire logic [2:0][15:0] req_data,
   // Segment A lock control
   input wire logic seg_a_unlock,
   input wire logic seg_a_lock,
   // Answers
   output logic busy_ff,
   output logic [2:0] grant_ff,
   output logic done_ff,
   output logic [15:0] rd_data_ff,
   output logic locked_hit_ff,
   output logic seg_a_locked_ff
);
   typedef enum {
      FSEP_IDLE,
      FSEP_WORK
   } fsep_state_type;

   localparam int TOT = fsep_pkg::MAIN_BYTES + fsep_pkg::INFO_BYTES;
   localparam int CNT_W = $clog2(TOT + 1);

   fsep_state_type state_ff;
   fsep_pkg::fsep_cmd_type cmd_ff;
   logic [1:0] src_sel;
   logic any_req;
   logic [fsep_pkg::ADDR_W-1:0] addr_ff;
   logic [15:0] data_ff;
   logic [CNT_W-1:0] left_ff;
   logic [1:0] step_ff;
   logic phase_ff;
   logic [7:0] arr_rd;
   logic arr_wr;
   logic arr_er;
   logic [7:0] arr_wd;
   logic [1:0] arr_margin;
   logic prot;

   // ------------------------------------------------------------
   // Decoding used by the lock protection and the sequencer
   // ------------------------------------------------------------
   function automatic logic in_seg_a(input logic [fsep_pkg::ADDR_W-1:0] a);
      logic [fsep_pkg::ADDR_W-1:0] off;
      off = a - fsep_pkg::INFO_BASE;
      return (a >= fsep_pkg::INFO_BASE) && (a < fsep_pkg::MAIN_BASE)
         && (off[fsep_pkg::INFO_SEG_SHIFT +: 2] == 2'(fsep_pkg::SEG_A_INDEX));
   endfunction

   // Segment base: aligns main addresses down in 512-byte steps from MAIN_BASE, info addresses to the 64-byte boundary
   function automatic logic [fsep_pkg::ADDR_W-1:0] seg_base(
      input logic [fsep_pkg::ADDR_W-1:0] a);
      logic [fsep_pkg::ADDR_W-1:0] off;
      off = a - fsep_pkg::MAIN_BASE;
      if (a < fsep_pkg::MAIN_BASE) begin
         return a & ~fsep_pkg::ADDR_W'(fsep_pkg::INFO_SEG_BYTES - 1);
      end
      return fsep_pkg::MAIN_BASE
         + (off & ~fsep_pkg::ADDR_W'(fsep_pkg::MAIN_SEG_BYTES - 1));
   endfunction

   // ------------------------------------------------------------
   // Fixed-priority arbiter: test port, then loader, then core
   // ------------------------------------------------------------
   always_comb begin
      any_req = |req_valid;
      if (req_valid[fsep_pkg::FSEP_SRC_TEST]) begin
         src_sel = 2'(fsep_pkg::FSEP_SRC_TEST);
      end else if (req_valid[fsep_pkg::FSEP_SRC_LOADER]) begin
         src_sel = 2'(fsep_pkg::FSEP_SRC_LOADER);
      end else begin
         src_sel = 2'(fsep_pkg::FSEP_SRC_CPU);
      end
   end

   // ------------------------------------------------------------
   // Lock for segment A; a lock request beats an unlock in the same cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seg_a_locked_ff <= 1'b1;
      end else if (seg_a_lock) begin
         seg_a_locked_ff <= 1'b1;
      end else if (seg_a_unlock && state_ff == FSEP_IDLE) begin
         seg_a_locked_ff <= 1'b0;
      end
   end

   // Protect the calibration records while locked
   assign prot = seg_a_locked_ff && in_seg_a(addr_ff);

   // ------------------------------------------------------------
   // Array strobes
   // ------------------------------------------------------------
   always_comb begin
      arr_wr = 1'b0;
      arr_er = 1'b0;
      arr_wd = phase_ff ? data_ff[15:8] : data_ff[7:0];
      arr_margin = 2'h0;
      if (state_ff == FSEP_WORK && step_ff == fsep_pkg::STEP_LAST && !prot) begin
         unique case (cmd_ff)
            fsep_pkg::FSEP_CMD_PROG_BYTE,
            fsep_pkg::FSEP_CMD_PROG_WORD: arr_wr = 1'b1;
            fsep_pkg::FSEP_CMD_ERASE_SEG,
            fsep_pkg::FSEP_CMD_ERASE_MAIN,
            fsep_pkg::FSEP_CMD_ERASE_ALL: arr_er = 1'b1;
            default: arr_er = 1'b0;
         endcase
      end
      // Margin 0 shows fresh zeros as ones, so a weakly held bit reads as erased
      if (cmd_ff == fsep_pkg::FSEP_CMD_READ_MARGIN0) begin
         arr_margin = 2'h1;
      end else if (cmd_ff == fsep_pkg::FSEP_CMD_READ_MARGIN1) begin
         arr_margin = 2'h0;
      end
   end

   fsep_array u_array (
      .clk(clk),
      .arst_n(arst_n),
      .addr(addr_ff),
      .wr_en(arr_wr),
      .wr_data(arr_wd),
      .er_en(arr_er),
      .margin(arr_margin),
      .rd_data(arr_rd)
   );

   // ------------------------------------------------------------
   // Sequencer: one byte per STEP_CYCLES; erase walks the range
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= FSEP_IDLE;
         cmd_ff <= fsep_pkg::FSEP_CMD_READ;
         addr_ff <= fsep_pkg::INFO_BASE;
         data_ff <= 16'h0000;
         left_ff <= '0;
         step_ff <= 2'h0;
         phase_ff <= 1'b0;
         busy_ff <= 1'b0;
         grant_ff <= 3'h0;
         done_ff <= 1'b0;
         rd_data_ff <= 16'h0000;
         locked_hit_ff <= 1'b0;
      end else begin
         grant_ff <= 3'h0;
         done_ff <= 1'b0;
         unique case (state_ff)
            FSEP_IDLE: begin
               if (any_req) begin
                  state_ff <= FSEP_WORK;
                  busy_ff <= 1'b1;
                  grant_ff <= 3'(1) << src_sel;
                  cmd_ff <= req_cmd[src_sel];
                  data_ff <= req_data[src_sel];
                  step_ff <= 2'h0;
                  phase_ff <= 1'b0;
                  locked_hit_ff <= 1'b0;
                  unique case (req_cmd[src_sel])
                     fsep_pkg::FSEP_CMD_PROG_WORD: begin
                        addr_ff <= req_addr[src_sel] & ~16'h0001; // Word is even aligned
                        left_ff <= CNT_W'(2);
                     end
                     fsep_pkg::FSEP_CMD_ERASE_SEG: begin
                        addr_ff <= seg_base(req_addr[src_sel]);
                        left_ff <= (req_addr[src_sel] < fsep_pkg::MAIN_BASE)
                           ? CNT_W'(fsep_pkg::INFO_SEG_BYTES)
                           : CNT_W'(fsep_pkg::MAIN_SEG_BYTES);
                     end
                     fsep_pkg::FSEP_CMD_ERASE_MAIN: begin
                        addr_ff <= fsep_pkg::MAIN_BASE;
                        left_ff <= CNT_W'(fsep_pkg::MAIN_BYTES);
                     end
                     fsep_pkg::FSEP_CMD_ERASE_ALL: begin
                        addr_ff <= fsep_pkg::INFO_BASE;
                        left_ff <= CNT_W'(TOT);
                     end
                     default: begin
                        addr_ff <= req_addr[src_sel];
                        left_ff <= CNT_W'(1);
                     end
                  endcase
               end
            end
            FSEP_WORK: begin
               step_ff <= step_ff + 2'h1;
               if (step_ff == fsep_pkg::STEP_LAST) begin
                  step_ff <= 2'h0;
                  if (prot && cmd_ff != fsep_pkg::FSEP_CMD_READ
                      && cmd_ff != fsep_pkg::FSEP_CMD_READ_MARGIN0
                      && cmd_ff != fsep_pkg::FSEP_CMD_READ_MARGIN1) begin
                     locked_hit_ff <= 1'b1;
                  end
                  if (phase_ff) begin
                     rd_data_ff[15:8] <= arr_rd;
                  end else begin
                     rd_data_ff <= {8'h00, arr_rd};
                  end
                  phase_ff <= ~phase_ff;
                  addr_ff <= addr_ff + 16'h0001;
                  left_ff <= left_ff - CNT_W'(1);
                  if (left_ff == CNT_W'(1)) begin
                     state_ff <= FSEP_IDLE;
                     busy_ff <= 1'b0;
                     done_ff <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
endmodule

// ---- tb/fsep_requester.sv ----
// Request source model for one port of the flash sequencer: core, loader or test port.
module fsep_requester (
   // Clock and bench control
   input wire logic clk,
   input wire logic start,
   input wire fsep_pkg::fsep_cmd_type cmd,
   input wire logic [15:0] addr,
   input wire logic [15:0] data,
   // Request port toward the sequencer
   input wire logic grant,
   output logic valid,
   output fsep_pkg::fsep_cmd_type o_cmd,
   output logic [15:0] o_addr,
   output logic [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle values at time zero
   initial begin
      valid = 1'b0;
      o_cmd = fsep_pkg::FSEP_CMD_READ;
      o_addr = 16'h0000;
      o_data = 16'h0000;
   end
   // Hold the request whole until its grant; released address and data lines flip so stale values never match, command holds
   always @(negedge clk) begin
      if (valid && grant) begin
         valid <= 1'b0;
         o_addr <= ~o_addr;
         o_data <= ~o_data;
      end else if (start && !valid) begin
         valid <= 1'b1;
         o_cmd <= cmd;
         o_addr <= addr;
         o_data <= data;
      end
   end
endmodule

// ---- tb/fsep_ctrl_monitor.sv ----
// Concurrent checks on the answer ports of the flash sequencer.
module fsep_ctrl_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Lock input and answers
   input wire logic seg_a_lock,
   input wire logic busy_ff,
   input wire logic [2:0] grant_ff,
   input wire logic done_ff,
   input wire logic locked_hit_ff,
   input wire logic seg_a_locked_ff
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ------------------------------------------------------------
   // Handshake and timing
   // ------------------------------------------------------------
   property p_grant_onehot; grant_ff != 3'h0 |-> $onehot(grant_ff) && busy_ff; endproperty
   a_grant_onehot: assert property (p_grant_onehot) else $error("grant bad");
   property p_grant_pulse; grant_ff != 3'h0 |=> grant_ff == 3'h0; endproperty
   a_grant_pulse: assert property (p_grant_pulse) else $error("grant long");
   property p_busy_cause; $rose(busy_ff) |-> grant_ff != 3'h0; endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy w/o grant");
   property p_no_early_done; grant_ff != 3'h0 |-> !done_ff ##1 !done_ff; endproperty
   a_no_early_done: assert property (p_no_early_done) else $error("done early");
   property p_done_end; done_ff |-> !busy_ff ##1 !done_ff; endproperty
   a_done_end: assert property (p_done_end) else $error("done bad");
   property p_busy_end; $fell(busy_ff) |-> done_ff; endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy fell w/o done");
   // ------------------------------------------------------------
   // Segment A lock
   // ------------------------------------------------------------
   property p_lock_reset; $rose(arst_n) |-> seg_a_locked_ff; endproperty
   a_lock_reset: assert property (p_lock_reset) else $error("unlocked at reset");
   property p_lock_set; seg_a_lock |=> seg_a_locked_ff; endproperty
   a_lock_set: assert property (p_lock_set) else $error("lock ignored");
   property p_unlock_busy; busy_ff && seg_a_locked_ff |=> seg_a_locked_ff; endproperty
   a_unlock_busy: assert property (p_unlock_busy) else $error("unlock in busy");
   property p_hit_locked; $rose(locked_hit_ff) |-> seg_a_locked_ff; endproperty
   a_hit_locked: assert property (p_hit_locked) else $error("hit unlocked");
   // Main scenarios reached
   c_test_port: cover property (grant_ff == 3'h4);
   c_hit: cover property ($rose(locked_hit_ff));
   c_back: cover property (done_ff ##1 grant_ff != 3'h0);
endmodule
bind fsep_ctrl fsep_ctrl_monitor fsep_ctrl_monitor_i (.clk, .arst_n, .seg_a_lock, .busy_ff,
   .grant_ff, .done_ff, .locked_hit_ff, .seg_a_locked_ff);

// ---- tb/flash_segment_erase_program_tb.sv ----
// Self-checking bench for the flash sequencer with three request sources.
module flash_segment_erase_program_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and model state
   // ------------------------------------------------------------
   logic clk, arst_n, seg_a_unlock, seg_a_lock, busy_ff, done_ff, locked_hit_ff, seg_a_locked_ff;
   logic [2:0] start, grant_ff;
   logic [15:0] rd_data_ff;
   // Nets, since each requester instance drives its own slice
   wire [2:0] req_valid;
   wire fsep_pkg::fsep_cmd_type [2:0] req_cmd;
   wire [2:0][15:0] req_addr, req_data;
   fsep_pkg::fsep_cmd_type s_cmd [3];
   logic [15:0] s_addr [3], s_data [3];
   logic [7:0] mem [int], wk [int];
   logic [31:0] seed, r;
   int num_errors, n_tests, cyc;
   bit mdl_lock, hit;
   fsep_ctrl fsep_ctrl_i (.clk, .arst_n, .req_valid, .req_cmd, .req_addr, .req_data,
      .seg_a_unlock, .seg_a_lock, .busy_ff, .grant_ff, .done_ff, .rd_data_ff,
      .locked_hit_ff, .seg_a_locked_ff);
   for (genvar g = 0; g < 3; g++) begin : g_src
      fsep_requester fsep_requester_i (.clk, .start(start[g]), .cmd(s_cmd[g]),
         .addr(s_addr[g]), .data(s_data[g]), .grant(grant_ff[g]), .valid(req_valid[g]),
         .o_cmd(req_cmd[g]), .o_addr(req_addr[g]), .o_data(req_data[g]));
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   // Erased cells are simply absent from the model; wk marks zeros programmed since erase
   function automatic logic [7:0] mb(int a);
      return mem.exists(a) ? mem[a] : 8'hff;
   endfunction
   function automatic logic [7:0] wkb(int a);
      return wk.exists(a) ? wk[a] : 8'h00;
   endfunction
   function automatic bit prot(int a);
      return mdl_lock && a >= 'h1000 && a < 'h1040;
   endfunction
   task automatic pgm(int a, logic [7:0] d);
      if (prot(a)) begin
         hit = 1;
      end else begin
         wk[a] = wkb(a) | (mb(a) & ~d);
         mem[a] = mb(a) & d;
      end
   endtask
   task automatic wipe(int lo, int n);
      for (int i = lo; i < lo + n; i++) begin
         if (prot(i)) begin
            hit = 1;
         end else begin
            mem.delete(i);
            wk.delete(i);
         end
      end
   endtask
   task automatic set(int s, fsep_pkg::fsep_cmd_type c, logic [15:0] a, logic [15:0] d);
      s_cmd[s] <= c;
      s_addr[s] <= a;
      s_data[s] <= d;
   endtask
   task automatic go(logic [2:0] m);
      @(negedge clk);
      start <= m;
      @(negedge clk);
      start <= 3'h0;
   endtask
   // Waits for grant and done, then checks timing, data and skip flag against the model
   task automatic finish(int s);
      int n, k;
      logic [15:0] a;
      a = s_addr[s];
      hit = 0;
      n = 1;
      k = 0;
      case (s_cmd[s])
         fsep_pkg::FSEP_CMD_PROG_WORD: n = 2;
         fsep_pkg::FSEP_CMD_ERASE_SEG: n = a < 'h1100 ? 64 : 512;
         fsep_pkg::FSEP_CMD_ERASE_MAIN: n = fsep_pkg::MAIN_BYTES;
         fsep_pkg::FSEP_CMD_ERASE_ALL: n = fsep_pkg::MAIN_BYTES + fsep_pkg::INFO_BYTES;
         default: ;
      endcase
      while (grant_ff === 3'h0 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk("grant", 16'(1 << s), 16'(grant_ff));
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (done_ff !== 1'b1 && k < 9000);
      chk("cycles", 16'(2 * n), 16'(k));
      case (s_cmd[s])
         fsep_pkg::FSEP_CMD_PROG_BYTE: pgm(a, s_data[s][7:0]);
         fsep_pkg::FSEP_CMD_PROG_WORD: begin
            pgm(a & ~1, s_data[s][7:0]);
            pgm((a & ~1) + 1, s_data[s][15:8]);
         end
         fsep_pkg::FSEP_CMD_ERASE_SEG: wipe(a < 'h1100 ? a & ~63 : 'h1100 + ((a - 'h1100) & ~511), n);
         fsep_pkg::FSEP_CMD_ERASE_MAIN: wipe('h1100, n);
         fsep_pkg::FSEP_CMD_ERASE_ALL: wipe('h1000, n);
         fsep_pkg::FSEP_CMD_READ_MARGIN0: begin
            chk("margin", {8'h00, mb(a) | wkb(a)}, rd_data_ff);
         end
         default: chk("read", {8'h00, mb(a)}, rd_data_ff);
      endcase
      chk("hit", 16'(hit), 16'(locked_hit_ff));
   endtask
   task automatic do1(int s, fsep_pkg::fsep_cmd_type c, logic [15:0] a, logic [15:0] d);
      set(s, c, a, d);
      go(3'(1 << s));
      finish(s);
   endtask
   task automatic lk(bit u);
      @(negedge clk);
      if (u) seg_a_unlock <= 1'b1;
      else seg_a_lock <= 1'b1;
      @(negedge clk);
      seg_a_unlock <= 1'b0;
      seg_a_lock <= 1'b0;
      @(negedge clk);
      mdl_lock = !u;
      chk("lock", 16'(mdl_lock), 16'(seg_a_locked_ff));
   endtask
   // Reset also returns the array to all ones and relocks segment A.
   // Called at time zero or at a falling edge, so reset spans exactly two rising edges.
   task automatic rst_seq();
      arst_n <= 1'b0;
      mem.delete();
      wk.delete();
      mdl_lock = 1;
      repeat (2) @(negedge clk);
      arst_n <= 1'b1;
      chk("lock", 16'h1, 16'(seg_a_locked_ff));
      chk("busy", 16'h0, 16'(busy_ff));
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, hang guard and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Longest run is one erase of all flash and one main erase, well under this ceiling
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      arst_n = 1'b0;
      seg_a_unlock = 1'b0;
      seg_a_lock = 1'b0;
      start = 3'h0;
      seed = 32'hd1c4;
      for (int i = 0; i < 3; i++) set(i, fsep_pkg::FSEP_CMD_READ, 16'h0, 16'h0);
      rst_seq();
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         s_addr[0] = 16'h1100 + 16'(r % 4096);
         do1(i % 3, i % 2 ? fsep_pkg::FSEP_CMD_PROG_WORD : fsep_pkg::FSEP_CMD_PROG_BYTE,
            s_addr[0], r[31:16]);
         do1(0, fsep_pkg::FSEP_CMD_READ, s_addr[0] | 1, 16'h0);
      end
      do1(0, fsep_pkg::FSEP_CMD_PROG_BYTE, 16'h1003, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1003, 16'h0);
      set(0, fsep_pkg::FSEP_CMD_READ, 16'h1100, 16'h0);
      set(1, fsep_pkg::FSEP_CMD_READ, 16'h1200, 16'h0);
      set(2, fsep_pkg::FSEP_CMD_READ, 16'h1040, 16'h0);
      go(3'h7);
      for (int s = 2; s >= 0; s--) finish(s);
      do1(1, fsep_pkg::FSEP_CMD_PROG_BYTE, 16'h1045, 16'h5a);
      do1(2, fsep_pkg::FSEP_CMD_ERASE_SEG, 16'h107f, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1045, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_PROG_BYTE, 16'h1305, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_PROG_BYTE, 16'h1500, 16'h0);
      do1(1, fsep_pkg::FSEP_CMD_ERASE_SEG, 16'h14ff, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1305, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1500, 16'h0);
      lk(1);
      do1(0, fsep_pkg::FSEP_CMD_PROG_WORD, 16'h1001, {fsep_pkg::CONVERTER_CALIBRATION_TAG,
         fsep_pkg::OSCILLATOR_CALIBRATION_TAG});
      do1(0, fsep_pkg::FSEP_CMD_READ_MARGIN1, 16'h1001, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ_MARGIN0, 16'h1000, 16'h0);
      lk(0);
      set(1, fsep_pkg::FSEP_CMD_ERASE_ALL, 16'h1000, 16'h0);
      go(3'h2);
      fork
         finish(1);
         begin
            repeat (4) @(negedge clk);
            seg_a_unlock <= 1'b1;
            @(negedge clk);
            seg_a_unlock <= 1'b0;
         end
      join
      chk("lock", 16'h1, 16'(seg_a_locked_ff));
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1000, 16'h0);
      do1(2, fsep_pkg::FSEP_CMD_PROG_BYTE, 16'h20ff, 16'h0);
      do1(2, fsep_pkg::FSEP_CMD_ERASE_MAIN, 16'h1100, 16'h0);
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h20ff, 16'h0);
      rst_seq();
      do1(0, fsep_pkg::FSEP_CMD_READ, 16'h1000, 16'h0);
      give_verdict();
   end
endmodule
